// file: hw/lso_top.sv
// Serial sample output lane: formatting, buffering and serializer.
// Assumes samples and settings come from logic on ref_clk_i; link_clk_i
// runs at the lane bit rate and free-runs.
//
// What this block does
// - 12x: full 12 bits, 6x bit clock
// - 10x: top ten bits, 5x bit clock
// - 14x factor for processed, wider samples
// - Bit clock 6x/5x/7x, frame clock 1x
// - Reset selects 12x until reprogrammed
// - Selectable MSB-first or LSB-first order
// - Two-bit bit clock phase, resets to 10
// - Two-bit data delays per clock edge
// - Three-bit bit clock rise/fall delays
// - Delay codes independent of serialization factor
// - One bit picks twos complement or offset
// - Positive overdrive clamps to full scale high
// - Negative overdrive alone clamps to full scale low; positive wins if both are set
// - All options set through control port
`timescale 1ns/1ps
`default_nettype none
module lso_top
  import lso_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  input wire logic cfg_wr_i,
  input wire logic [1:0] ser_sel_i,
  input wire logic lsb_first_i,
  input wire logic twos_complement_sel_i,
  input wire logic [1:0] bit_clock_phase_i,
  input wire logic [1:0] data_rise_delay_i,
  input wire logic [1:0] data_fall_delay_i,
  input wire logic [2:0] bit_clock_edge_delay_i,
  input wire logic [2:0] bit_clock_fall_delay_i,
  input wire logic sample_valid_i,
  input wire logic [SMP_W-1:0] sample_code_i,
  input wire logic [EXT_W-1:0] sample_ext_i,
  input wire logic ovr_pos_i,
  input wire logic ovr_neg_i,
  output logic sample_ready_o,
  output logic [1:0] cur_ser_o,
  output logic [1:0] bit_clock_phase_o,
  output logic [1:0] data_rise_delay_o,
  output logic [1:0] data_fall_delay_o,
  output logic [2:0] bit_clock_edge_delay_o,
  output logic [2:0] bit_clock_fall_delay_o,
  output logic serial_data_o,
  output logic output_bit_clock_o,
  output logic frame_clock_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (BUF_DEPTH != 2)
  begin : g_bad_buf
    $error("lso_top: the sample buffer holds exactly two entries");
  end

  // ----------------------------------------
  // Settings, reference domain
  // ----------------------------------------
  lso_cfg_t cfg_ff, nxt_cfg; // Live settings
  lso_cfg_t cfg_in; // Settings offered on the port

  // Gather port settings
  always_comb
  begin
    cfg_in.ser = lso_ser_t'(ser_sel_i);
    cfg_in.lsb_first = lsb_first_i;
    cfg_in.twos_comp = twos_complement_sel_i;
    cfg_in.phase = bit_clock_phase_i;
    cfg_in.dly_data_r = data_rise_delay_i;
    cfg_in.dly_data_f = data_fall_delay_i;
    cfg_in.dly_clk_r = bit_clock_edge_delay_i;
    cfg_in.dly_clk_f = bit_clock_fall_delay_i;
  end

  // Write strobe loads all options at once, the factor only for a used code
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (cfg_wr_i)
    begin
      nxt_cfg = cfg_in;
      if (ser_sel_i == SER_BAD)
      begin
        nxt_cfg.ser = cfg_ff.ser; // Unused code keeps the factor
      end
    end
  end

  // Register settings, reset to defaults
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_ff.ser <= SER_12X;
      cfg_ff.lsb_first <= 1'b0;
      cfg_ff.twos_comp <= 1'b0;
      cfg_ff.phase <= PHASE_RST;
      cfg_ff.dly_data_r <= DDLY_RST;
      cfg_ff.dly_data_f <= DDLY_RST;
      cfg_ff.dly_clk_r <= CR_DLY_RST;
      cfg_ff.dly_clk_f <= CF_DLY_RST;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Codes go straight to the analog delay cells, whatever the factor
  assign data_rise_delay_o = cfg_ff.dly_data_r;
  assign data_fall_delay_o = cfg_ff.dly_data_f;
  assign bit_clock_edge_delay_o = cfg_ff.dly_clk_r;
  assign bit_clock_fall_delay_o = cfg_ff.dly_clk_f;
  assign bit_clock_phase_o = cfg_ff.phase;
  assign cur_ser_o = cfg_ff.ser;

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  lso_smp_t smp_in, smp_out; // Buffer ends
  logic buf_valid; // Buffer holds a sample
  logic pop; // Sample taken toward the link
  logic busy; // Link has not taken the last word
  logic ack_ff, nxt_ack; // Acknowledge toggle, link domain

  assign smp_in = '{code: sample_code_i, ext: sample_ext_i,
                    ovr_pos: ovr_pos_i, ovr_neg: ovr_neg_i};

  lso_buf #(
    .W($bits(lso_smp_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(smp_in),
    .in_ready_o(sample_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(smp_out),
    .out_ready_i(!busy)
  );

  // ----------------------------------------
  // Formatting and hand-off to link domain
  // ----------------------------------------
  lso_word_t hold_ff, nxt_hold; // Word offered to the link
  lso_word_t fmt; // Formatted buffer head
  logic req_ff, nxt_req; // Request toggle
  logic rack_s1, rack_s2; // Acknowledge synchroniser
  logic [SMP_W-1:0] code; // Clamped, recoded sample

  assign busy = (req_ff != rack_s2);
  assign pop = buf_valid && !busy;

  // Clamp on overdrive, then pick the coding
  always_comb
  begin
    code = smp_out.code;
    if (smp_out.ovr_pos)
    begin
      code = CODE_OB_POS;
    end
    else if (smp_out.ovr_neg)
    begin
      code = CODE_OB_NEG;
    end
    if (cfg_ff.twos_comp)
    begin
      code[MSB_POS] = !code[MSB_POS];
    end
    fmt.bits = {code, smp_out.ext};
    if (smp_out.ovr_pos || smp_out.ovr_neg)
    begin
      fmt.bits[EXT_W-1:0] = {EXT_W{smp_out.ovr_pos}};
    end
    fmt.ser = cfg_ff.ser;
    fmt.lsb_first = cfg_ff.lsb_first;
    fmt.phase = cfg_ff.phase;
  end

  // Capture word and raise request
  always_comb
  begin
    nxt_hold = hold_ff;
    nxt_req = req_ff;
    if (pop)
    begin
      nxt_hold = fmt;
      nxt_req = !req_ff;
    end
  end

  // Register hand-off state
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      hold_ff <= '0;
      req_ff <= 1'b0;
      rack_s1 <= 1'b0;
      rack_s2 <= 1'b0;
    end
    else
    begin
      hold_ff <= nxt_hold;
      req_ff <= nxt_req;
      rack_s1 <= ack_ff;
      rack_s2 <= rack_s1;
    end
  end

  // ----------------------------------------
  // Serializer, link domain
  // ----------------------------------------
  typedef enum logic {
    LS_IDLE = 1'b0,
    LS_RUN = 1'b1
  } lso_lst_t;

  lso_lst_t st_ff, nxt_st; // Serializer state
  logic lrst_s1, lrst_s2; // Reset synchroniser
  logic lreq_s1, lreq_s2; // Request synchroniser
  logic [WORD_W-1:0] sh_ff, nxt_sh; // Shift register
  logic [3:0] cnt_ff, nxt_cnt; // Bit index in frame
  logic [3:0] nb_ff, nxt_nb; // Frame length
  logic dout_ff, nxt_dout; // Lane data
  logic bclk_ff, nxt_bclk; // Bit clock
  logic fclk_ff, nxt_fclk; // Frame clock
  logic load; // Take a new word
  logic last; // Final bit of a frame
  logic [3:0] ln; // Length of the offered word
  logic [WORD_W-1:0] ord; // Word in send order

  // Reverse an n-bit field held at the top
  function automatic logic [WORD_W-1:0] rev_top(input logic [WORD_W-1:0] b,
                                                input logic [3:0] n);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      if (i < int'(n))
      begin
        r[WORD_W-1-i] = b[WORD_W-int'(n)+i];
      end
    end
    return r;
  endfunction

  assign ln = nbits(hold_ff.ser);
  assign last = (st_ff == LS_IDLE) || (cnt_ff == nb_ff - 4'h1);
  assign load = last && (lreq_s2 != ack_ff);
  assign ord = hold_ff.lsb_first ? rev_top(hold_ff.bits, ln) : hold_ff.bits;

  // Next serializer values
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ack = ack_ff;
    nxt_sh = {sh_ff[WORD_W-2:0], 1'b0};
    nxt_cnt = cnt_ff + 4'h1;
    nxt_nb = nb_ff;
    nxt_dout = sh_ff[WORD_W-1];
    nxt_bclk = !bclk_ff;
    nxt_fclk = (nxt_cnt < (nb_ff >> 1));
    if (load)
    begin
      nxt_st = LS_RUN;
      nxt_ack = lreq_s2;
      nxt_sh = {ord[WORD_W-2:0], 1'b0};
      nxt_cnt = 4'h0;
      nxt_nb = ln;
      nxt_dout = ord[WORD_W-1];
      nxt_bclk = hold_ff.phase[1];
      nxt_fclk = 1'b1;
    end
    else if (last)
    begin
      nxt_st = LS_IDLE; // No word ready, lane rests low
      nxt_cnt = 4'h0;
      nxt_dout = 1'b0;
      nxt_fclk = 1'b0;
    end
  end

  // Register serializer, reset from synchronised reset
  always_ff @(posedge link_clk_i)
  begin
    lrst_s1 <= rstn_i;
    lrst_s2 <= lrst_s1;
    if (!lrst_s2)
    begin
      st_ff <= LS_IDLE;
      lreq_s1 <= 1'b0;
      lreq_s2 <= 1'b0;
      ack_ff <= 1'b0;
      sh_ff <= '0;
      cnt_ff <= 4'h0;
      nb_ff <= NBITS_12;
      dout_ff <= 1'b0;
      bclk_ff <= 1'b0;
      fclk_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      lreq_s1 <= req_ff;
      lreq_s2 <= lreq_s1;
      ack_ff <= nxt_ack;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      nb_ff <= nxt_nb;
      dout_ff <= nxt_dout;
      bclk_ff <= nxt_bclk;
      fclk_ff <= nxt_fclk;
    end
  end

  assign serial_data_o = dout_ff;
  assign output_bit_clock_o = bclk_ff;
  assign frame_clock_o = fclk_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_defaults: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> (cfg_ff.ser == SER_12X) && (cfg_ff.phase == PHASE_RST))
    else $error("settings not at defaults after reset");

  a_pos_clamp: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pop && smp_out.ovr_pos |=> hold_ff.bits[WORD_W-1:EXT_W] ==
      ($past(cfg_ff.twos_comp) ? CODE_TC_POS : CODE_OB_POS))
    else $error("positive overdrive not clamped");

  a_neg_clamp: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pop && smp_out.ovr_neg && !smp_out.ovr_pos |=> hold_ff.bits[WORD_W-1:EXT_W] ==
      ($past(cfg_ff.twos_comp) ? CODE_TC_NEG : CODE_OB_NEG))
    else $error("negative overdrive not clamped");

  a_tc_msb_flip: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pop && !smp_out.ovr_pos && !smp_out.ovr_neg |=>
      hold_ff.bits[WORD_W-1] == ($past(smp_out.code[MSB_POS]) ^ $past(cfg_ff.twos_comp)))
    else $error("coding bit not applied");

  a_delay_codes: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    cfg_wr_i |=> (data_rise_delay_o == $past(data_rise_delay_i)) &&
      (bit_clock_fall_delay_o == $past(bit_clock_fall_delay_i)))
    else $error("delay code not loaded");

  a_bitclk_ddr: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    !load |=> output_bit_clock_o != $past(output_bit_clock_o))
    else $error("bit clock missed a toggle");

  a_phase_start: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    load |=> output_bit_clock_o == $past(hold_ff.phase[1]))
    else $error("bit clock phase wrong at frame start");

  a_frame_12x: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    load && hold_ff.ser == SER_12X |=> frame_clock_o [*6] ##1 !frame_clock_o
      ##5 (cnt_ff == 4'hB))
    else $error("12x frame shape wrong");

  a_frame_10x: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    load && hold_ff.ser == SER_10X |=> (cnt_ff == 4'h0) ##9 (cnt_ff == 4'h9))
    else $error("10x frame length wrong");

  a_frame_14x: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    load && hold_ff.ser == SER_14X |=> frame_clock_o [*7] ##1 !frame_clock_o
      ##6 (cnt_ff == 4'hD))
    else $error("14x frame shape wrong");

  a_bit_order: assert property (@(posedge link_clk_i) disable iff (!lrst_s2)
    load && hold_ff.ser == SER_12X |=> serial_data_o ==
      ($past(hold_ff.lsb_first) ? $past(hold_ff.bits[EXT_W]) : $past(hold_ff.bits[WORD_W-1])))
    else $error("first bit of frame in wrong order");

endmodule
`default_nettype wire

// file: hw/lso_pkg.sv
// Constants, modes and carriers for the serial sample output block.
// Assumes one sample lane; analog delay cells sit outside and take the codes.
package lso_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SMP_W = 12; // Converter code width
  localparam int EXT_W = 2; // Extra precision bits from digital processing
  localparam int WORD_W = SMP_W + EXT_W; // Widest serial word

  // ----------------------------------------
  // Serialization factors
  // ----------------------------------------
  typedef enum logic [1:0] {
    SER_12X = 2'h0,
    SER_10X = 2'h1,
    SER_14X = 2'h2
  } lso_ser_t;
  localparam logic [1:0] SER_BAD = 2'h3; // Code that a write may not select
  localparam logic [3:0] NBITS_12 = 4'hC; // Bits per frame at 12x
  localparam logic [3:0] NBITS_10 = 4'hA; // Bits per frame at 10x
  localparam logic [3:0] NBITS_14 = 4'hE; // Bits per frame at 14x
  localparam int MAX_RATE_12X_MBPS = 960; // Lane rate limit at 12x
  localparam int MAX_RATE_10X_MBPS = 1000; // Lane rate limit at 10x

  // ----------------------------------------
  // Output codes on overdrive
  // ----------------------------------------
  localparam logic [11:0] CODE_OB_POS = 12'hFFF;
  localparam logic [11:0] CODE_OB_NEG = 12'h000;
  localparam logic [11:0] CODE_TC_POS = 12'h7FF;
  localparam logic [11:0] CODE_TC_NEG = 12'h800;
  localparam int MSB_POS = SMP_W - 1; // Sign bit position of the code

  // ----------------------------------------
  // Reset values of the settings
  // ----------------------------------------
  localparam logic [1:0] PHASE_RST = 2'h2; // Bit clock phase code
  localparam logic [1:0] DDLY_RST = 2'h0; // Data delay code, 0 ps
  localparam logic [2:0] CR_DLY_RST = 3'h4; // Clock rise delay code, 0 ps
  localparam logic [2:0] CF_DLY_RST = 3'h3; // Clock fall delay code, 0 ps
  localparam int DATA_DLY_PS [4] = '{0, 33, 72, 120}; // Typical data delays
  localparam int CR_DLY_PS [8] = '{-106, -73, -34, 14, 0, 53, 96, 138};
  localparam int CF_DLY_PS [8] = '{-120, -87, -48, 0, -14, 39, 82, 124};

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    lso_ser_t ser; // Serialization factor
    logic lsb_first; // Bit order
    logic twos_comp; // Output coding
    logic [1:0] phase; // Bit clock phase
    logic [1:0] dly_data_r; // Data delay, rising edge
    logic [1:0] dly_data_f; // Data delay, falling edge
    logic [2:0] dly_clk_r; // Bit clock rise delay
    logic [2:0] dly_clk_f; // Bit clock fall delay
  } lso_cfg_t;

  typedef struct packed {
    logic [SMP_W-1:0] code; // Offset binary code
    logic [EXT_W-1:0] ext; // Extra low bits
    logic ovr_pos; // Positive overdrive
    logic ovr_neg; // Negative overdrive
  } lso_smp_t;

  typedef struct packed {
    logic [WORD_W-1:0] bits; // MSB-aligned formatted word
    lso_ser_t ser; // Frame length
    logic lsb_first; // Bit order
    logic [1:0] phase; // Bit clock phase
  } lso_word_t;

  // Bits per frame for a factor
  function automatic logic [3:0] nbits(input lso_ser_t s);
    logic [3:0] n;
    n = NBITS_12;
    if (s == SER_10X)
    begin
      n = NBITS_10;
    end
    else if (s == SER_14X)
    begin
      n = NBITS_14;
    end
    return n;
  endfunction

endpackage

// file: hw/lso_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; ready on the filling side comes from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module lso_buf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("lso_buf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ff, nxt_wr; // Write pointer
  logic [AW-1:0] rd_ff, nxt_rd; // Read pointer
  logic [AW:0] cnt_ff, nxt_cnt; // Fill level
  logic rdy_ff, nxt_rdy; // Registered room flag
  logic in_fire, out_fire;

  assign in_fire = in_valid_i && rdy_ff;
  assign out_fire = out_valid_o && out_ready_i;
  assign in_ready_o = rdy_ff;
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem[rd_ff];

  // Pointer and level update
  always_comb
  begin
    nxt_wr = wr_ff + AW'(in_fire);
    nxt_rd = rd_ff + AW'(out_fire);
    nxt_cnt = cnt_ff + (AW + 1)'(in_fire) - (AW + 1)'(out_fire);
    nxt_rdy = (nxt_cnt != FULL);
  end

  // Register state
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (in_fire)
    begin
      mem[wr_ff] <= in_data_i;
    end
  end

endmodule
`default_nettype wire

// file: bench/lso_rx.sv
// Receiver model: deserializes one lane on the link clock.
// Assumes bench tells it the frame length; outputs settle after posedge.
`timescale 1ns/1ps
`default_nettype none
module lso_rx
  import lso_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rstn_i,
  input wire logic serial_data_i,
  input wire logic frame_clock_i,
  input wire logic bit_clock_i,
  input wire logic [3:0] nbits_i,
  output logic [WORD_W-1:0] word_o,
  output logic word_vld_o,
  output logic [3:0] fhi_o,
  output logic first_bclk_o,
  output logic [3:0] stuck_o
);
  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  logic fclk_q = 1'b0; // Last frame clock level
  logic bclk_q = 1'b0; // Last bit clock level
  logic [3:0] cnt = 4'h0; // Bits taken in this frame
  logic [WORD_W-1:0] sh = '0; // Shift register, first bit ends on top
  logic [3:0] hi = 4'h0; // Frame clock high count
  logic [3:0] stk = 4'h0; // Bits where bit clock failed to toggle

  // One bit per link cycle; bit clock flips each bit
  always @(posedge link_clk_i)
  begin
    word_vld_o <= 1'b0;
    fclk_q <= frame_clock_i;
    bclk_q <= bit_clock_i;
    if (!rstn_i)
    begin
      cnt <= 4'h0;
      fclk_q <= 1'b0;
    end
    else if (frame_clock_i && !fclk_q)
    begin
      // Frame clock rise marks a word start
      sh <= {{(WORD_W-1){1'b0}}, serial_data_i};
      cnt <= 4'h1;
      hi <= 4'h1;
      stk <= 4'h0;
      first_bclk_o <= bit_clock_i;
    end
    else if (cnt != 4'h0)
    begin
      sh <= {sh[WORD_W-2:0], serial_data_i};
      hi <= hi + {3'h0, frame_clock_i};
      stk <= stk + {3'h0, bit_clock_i == bclk_q};
      cnt <= cnt + 4'h1;
      if (cnt + 4'h1 == nbits_i)
      begin
        // Last bit: hand the word out
        word_o <= {sh[WORD_W-2:0], serial_data_i};
        fhi_o <= hi + {3'h0, frame_clock_i};
        stuck_o <= stk + {3'h0, bit_clock_i == bclk_q};
        word_vld_o <= 1'b1;
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/lso_top_tb.sv
// Bench for the serial sample output lane.
// Assumes the lso_rx receiver model; both clocks are made here.
`timescale 1ns/1ps
`default_nettype none
module lso_top_tb
  import lso_pkg::*;
;
  // ----------------------------------------
  // Clocks, stimulus and counters
  // ----------------------------------------
  logic ref_clk_i, link_clk_i, rstn_i, cfg_wr_i, lsb_first_i, twos_complement_sel_i;
  logic [1:0] ser_sel_i, bit_clock_phase_i, data_rise_delay_i, data_fall_delay_i;
  logic [2:0] bit_clock_edge_delay_i, bit_clock_fall_delay_i;
  logic sample_valid_i, ovr_pos_i, ovr_neg_i;
  logic [SMP_W-1:0] sample_code_i;
  logic [EXT_W-1:0] sample_ext_i;
  logic sample_ready_o, serial_data_o, output_bit_clock_o, frame_clock_o;
  logic [1:0] cur_ser_o, bit_clock_phase_o, data_rise_delay_o, data_fall_delay_o;
  logic [2:0] bit_clock_edge_delay_o, bit_clock_fall_delay_o;
  logic [WORD_W-1:0] rx_word;
  logic rx_vld, rx_fb;
  logic [3:0] rx_fhi, rx_stk, rx_n;
  logic [1:0] b_ser = 2'h0; // Live factor as the bench expects it
  logic b_lsb = 1'b0, b_tc = 1'b0;
  logic [1:0] b_ph = 2'h2;
  logic [WORD_W-1:0] exp_q[$]; // Words owed by the lane
  int n_errors = 0, total_checks = 0, refused = 0;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #7;
    forever #32 link_clk_i = ~link_clk_i;
  end

  lso_top #(.BUF_DEPTH(2)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .link_clk_i(link_clk_i), .cfg_wr_i(cfg_wr_i), .ser_sel_i(ser_sel_i),
    .lsb_first_i(lsb_first_i), .twos_complement_sel_i(twos_complement_sel_i),
    .bit_clock_phase_i(bit_clock_phase_i), .data_rise_delay_i(data_rise_delay_i),
    .data_fall_delay_i(data_fall_delay_i), .bit_clock_edge_delay_i(bit_clock_edge_delay_i),
    .bit_clock_fall_delay_i(bit_clock_fall_delay_i), .sample_valid_i(sample_valid_i),
    .sample_code_i(sample_code_i), .sample_ext_i(sample_ext_i), .ovr_pos_i(ovr_pos_i),
    .ovr_neg_i(ovr_neg_i), .sample_ready_o(sample_ready_o), .cur_ser_o(cur_ser_o),
    .bit_clock_phase_o(bit_clock_phase_o), .data_rise_delay_o(data_rise_delay_o),
    .data_fall_delay_o(data_fall_delay_o), .bit_clock_edge_delay_o(bit_clock_edge_delay_o),
    .bit_clock_fall_delay_o(bit_clock_fall_delay_o), .serial_data_o(serial_data_o),
    .output_bit_clock_o(output_bit_clock_o), .frame_clock_o(frame_clock_o));

  lso_rx rx (.link_clk_i(link_clk_i), .rstn_i(rstn_i), .serial_data_i(serial_data_o),
    .frame_clock_i(frame_clock_o), .bit_clock_i(output_bit_clock_o), .nbits_i(rx_n),
    .word_o(rx_word), .word_vld_o(rx_vld), .fhi_o(rx_fhi), .first_bclk_o(rx_fb),
    .stuck_o(rx_stk));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bits per frame for a factor code
  function automatic logic [3:0] bits_of(input logic [1:0] s);
    return (s == 2'h1) ? 4'hA : (s == 2'h2) ? 4'hE : 4'hC;
  endfunction

  // Serial word in arrival order, first bit on top
  function automatic logic [WORD_W-1:0] exp_word(input logic [11:0] c, input logic [1:0] e,
                                                input logic p, input logic ng);
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] r;
    int n;
    n = bits_of(b_ser);
    if (p)
    begin
      c = 12'hFFF;
      e = 2'h3;
    end
    else if (ng)
    begin
      c = 12'h000;
      e = 2'h0;
    end
    if (b_tc)
      c[11] = ~c[11];
    w = {c, e} >> (14 - n);
    r = w;
    if (b_lsb)
      for (int k = 0; k < n; k++)
        r[k] = w[n-1-k];
    return r;
  endfunction

  // Every finished frame is matched against the oldest owed word
  always @(negedge link_clk_i)
  begin
    if (rx_vld === 1'b1)
    begin
      check(rx_word, (exp_q.size() != 0) ? exp_q.pop_front() : 32'hFFFF_FFFF);
      check(rx_fhi, {1'b0, rx_n[3:1]});
      check(rx_fb, b_ph[1]);
      check(rx_stk, 4'h0);
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic settings_ok();
    @(negedge ref_clk_i);
    check(bit_clock_phase_o, b_ph);
    check(cur_ser_o, b_ser);
  endtask

  task automatic cfg(input logic [1:0] s, input logic l, input logic t);
    logic [9:0] d;
    d = 10'($urandom);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    ser_sel_i <= s;
    lsb_first_i <= l;
    twos_complement_sel_i <= t;
    bit_clock_phase_i <= d[1:0];
    {data_rise_delay_i, data_fall_delay_i, bit_clock_edge_delay_i, bit_clock_fall_delay_i} <=
      {d[1:0], d[3:2], d[6:4], d[9:7]};
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
    if (s != 2'h3)
      b_ser = s;
    {b_lsb, b_tc, b_ph} = {l, t, d[1:0]};
    rx_n = bits_of(b_ser);
    settings_ok();
    check({data_rise_delay_o, data_fall_delay_o}, {d[1:0], d[3:2]});
    check({bit_clock_edge_delay_o, bit_clock_fall_delay_o}, {d[6:4], d[9:7]});
    @(posedge ref_clk_i);
  endtask

  // Offer one sample; held until taken
  task automatic send(input logic [11:0] c, input logic [1:0] e, input logic p, input logic ng);
    int k;
    sample_valid_i <= 1'b1;
    {sample_code_i, sample_ext_i, ovr_pos_i, ovr_neg_i} <= {c, e, p, ng};
    k = 0;
    @(negedge ref_clk_i);
    while (sample_ready_o !== 1'b1 && k < 4000)
    begin
      refused++;
      k++;
      @(negedge ref_clk_i);
    end
    if (k >= 4000)
    begin
      n_errors++;
      conclude();
    end
    @(posedge ref_clk_i);
    exp_q.push_back(exp_word(c, e, p, ng));
  endtask

  // Overdrive corners then random codes, back to back, then drain
  task automatic batch();
    int k;
    refused = 0;
    send(12'h123, 2'h1, 1'b1, 1'b0);
    send(12'hABC, 2'h2, 1'b0, 1'b1);
    send(12'h456, 2'h0, 1'b1, 1'b1);
    repeat (5) send(12'($urandom), 2'($urandom), 1'b0, 1'b0);
    sample_valid_i <= 1'b0;
    sample_code_i <= ~sample_code_i;
    k = 0;
    while (exp_q.size() != 0 && k < 20000)
    begin
      k++;
      @(posedge ref_clk_i);
    end
    check(k < 20000, 1'b1);
    if (k >= 20000)
      conclude();
    check(refused != 0, 1'b1);
    repeat (60) @(posedge ref_clk_i);
    $display("batch done ser=%0d lsb=%0d tc=%0d", b_ser, b_lsb, b_tc);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn_i, cfg_wr_i, lsb_first_i, twos_complement_sel_i, sample_valid_i} = 5'h0;
    {ser_sel_i, bit_clock_phase_i, data_rise_delay_i, data_fall_delay_i} = 8'h0;
    {bit_clock_edge_delay_i, bit_clock_fall_delay_i, sample_ext_i} = 8'h0;
    {sample_code_i, ovr_pos_i, ovr_neg_i} = 14'h0;
    rx_n = 4'hC;
    void'($urandom(32'h0443));
    repeat (8) @(posedge ref_clk_i);
    settings_ok();
    check(sample_ready_o, 1'b0);
    check({data_rise_delay_o, data_fall_delay_o}, 4'h0);
    check({bit_clock_edge_delay_o, bit_clock_fall_delay_o}, 6'h23);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    $display("reset done");
    batch();
    for (int i = 0; i < 6; i++)
    begin
      cfg(2'(i % 3), i >= 3, i[0]);
      batch();
    end
    cfg(2'h3, 1'b0, 1'b1);
    batch();
    conclude();
  end
endmodule
`default_nettype wire
